// ---- common/cogsd_consts.svh ----
// Register offsets, field positions and reset values of the shutdown/timing block
// Assumes an 8-bit register port with a 4-bit word address
`ifndef COGSD_CONSTS_SVH
`define COGSD_CONSTS_SVH
`define COGSD_OFF_CTRL_A   4'h0
`define COGSD_OFF_CTRL_B   4'h1
`define COGSD_OFF_CNT0     4'h2
`define COGSD_OFF_CNT5     4'h7
`define COGSD_OFF_SD_CTRL  4'h8
`define COGSD_OFF_SD_SRC   4'h9
`define COGSD_OFF_STATUS   4'hA
`define COGSD_OFF_ALT_PIN  4'hB
`define COGSD_CA_EN        7
`define COGSD_CA_OE1       6
`define COGSD_CA_OE0       5
`define COGSD_CA_POL1      4
`define COGSD_CA_POL0      3
`define COGSD_CA_LD        2
`define COGSD_SD_ASDE      7
`define COGSD_SD_ARSEN     6
`define COGSD_SD_LVLB_HI   5
`define COGSD_SD_LVLB_LO   4
`define COGSD_SD_LVLA_HI   3
`define COGSD_SD_LVLA_LO   2
`define COGSD_RST_BYTE     8'h00
`define COGSD_DIV4_LAST    2'h3
`define COGSD_CNT_IDX_PH_R 3'h0
`endif

// ---- common/cogsd_pkg.sv ----
// Types shared by the shutdown/timing block
// Assumes the constants header for all numeric offsets
package cogsd_pkg;
   typedef enum logic [1:0] {
      COGSD_LVL_LOW  = 2'b00,
      COGSD_LVL_HIGH = 2'b01,
      COGSD_LVL_TRI  = 2'b10,
      COGSD_LVL_INACT = 2'b11
   } cogsd_lvl_t;
   typedef enum logic [1:0] {
      COGSD_CS_SYS  = 2'b00,
      COGSD_CS_DIV4 = 2'b01,
      COGSD_CS_FAST = 2'b10,
      COGSD_CS_RSV  = 2'b11
   } cogsd_cs_t;
   typedef enum logic {
      COGSD_ST_RUN  = 1'b0,
      COGSD_ST_SHUT = 1'b1
   } cogsd_st_t;
endpackage

// ---- hdl/cogsd_tick.sv ----
// Generator clock enable: selects system, divided-by-four or fast oscillator rate
// Assumes fast_tick is a one-cycle pulse synchronous to core_clk
`timescale 1ns/10ps
`include "cogsd_consts.svh"
module cogsd_tick (
   input  wire logic              core_clk,  // System clock
   input  wire logic              rst_n,     // Synchronised reset
   input  wire cogsd_pkg::cogsd_cs_t cs,     // Clock source select
   input  wire logic              fast_tick, // Fast oscillator rate pulse
   input  wire logic              en,        // Module enable
   output logic                   gen_tick,  // Generator clock enable
   output logic                   osc_keep   // Keep fast oscillator on in sleep
);
   logic [1:0] div_r;
   wire div_hit = (div_r == `COGSD_DIV4_LAST);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) div_r <= 2'h0;
      else        div_r <= div_r + 2'h1;
   end

   always_comb begin
      unique case (cs)
         cogsd_pkg::COGSD_CS_SYS:  gen_tick = 1'b1; // R23
         cogsd_pkg::COGSD_CS_DIV4: gen_tick = div_hit; // R23
         cogsd_pkg::COGSD_CS_FAST: gen_tick = fast_tick; // R23
         cogsd_pkg::COGSD_CS_RSV:  gen_tick = 1'b0; // R23
      endcase
   end
   // Sleep does not stop the block; only the oscillator request matters
   assign osc_keep = en && (cs == cogsd_pkg::COGSD_CS_FAST); // R18

   property p_div4;
      @(posedge core_clk) disable iff (!rst_n)
      (cs == cogsd_pkg::COGSD_CS_DIV4) && gen_tick |=> !gen_tick;
   endproperty
   a_div4: assert property (p_div4) else $error("div4 tick too fast"); // R23
   property p_rsv;
      @(posedge core_clk) disable iff (!rst_n)
      (cs == cogsd_pkg::COGSD_CS_RSV) |-> !gen_tick;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved source ticked"); // R23
   property p_osc;
      @(posedge core_clk) disable iff (!rst_n)
      en && (cs == cogsd_pkg::COGSD_CS_FAST) |-> osc_keep;
   endproperty
   a_osc: assert property (p_osc) else $error("fast oscillator released"); // R18
endmodule // cogsd_tick

// ---- hdl/cogsd_stage.sv ----
// One timing stage: phase, dead-band or blanking counter
// Assumes tick is the generator clock enable, and in_lvl is synchronous
`timescale 1ns/10ps
module cogsd_stage #(
   parameter int W = 8
) (
   input  wire logic         core_clk, // System clock
   input  wire logic         rst_n,    // Synchronised reset
   input  wire logic         tick,     // Generator clock enable
   input  wire logic [W-1:0] cnt,      // Active count
   input  wire logic         in_lvl,   // Stage input level
   output logic              out_lvl,  // Delayed rising edge, immediate fall
   output logic              busy      // Counting in progress
);
   logic [W-1:0] ctr_r;
   logic         in_q_r;
   logic         run_r;
   logic         done_r;
   logic [W-1:0] hi_r;
   wire zero = (cnt == '0);
   wire start = in_lvl && !in_q_r && !zero;
   wire last = run_r && tick && (ctr_r <= {{(W-1){1'b0}}, 1'b1});

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_q_r <= 1'b0;
         run_r  <= 1'b0;
         done_r <= 1'b0;
         ctr_r  <= '0;
      end else begin
         in_q_r <= in_lvl;
         if (!in_lvl) begin
            run_r  <= 1'b0;
            done_r <= 1'b0;
         end else if (start) begin
            run_r <= 1'b1;
            ctr_r <= cnt; // R4
         end else if (last) begin
            run_r  <= 1'b0;
            done_r <= 1'b1;
         end else if (run_r && tick) begin
            ctr_r <= ctr_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
   // Output changes only on a clock edge, so a following stage adds no uncertainty
   assign out_lvl = zero ? in_lvl : (done_r && in_lvl); // R1 R2
   assign busy = run_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n)                  hi_r <= '0;
      else if (!in_lvl)            hi_r <= '0;
      else if (hi_r != {W{1'b1}})  hi_r <= hi_r + {{(W-1){1'b0}}, 1'b1};
   end
   property p_bypass;
      @(posedge core_clk) disable iff (!rst_n)
      zero |-> (out_lvl == in_lvl);
   endproperty
   a_bypass: assert property (p_bypass) else $error("zero count not bypassed"); // R1
   property p_min_delay;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(out_lvl) && !zero |-> (hi_r >= cnt);
   endproperty
   a_min_delay: assert property (p_min_delay) else $error("stage delay short"); // R4
endmodule // cogsd_stage

// ---- hdl/cogsd_top.sv ----
// Complementary generator timing, auto-shutdown and buffered count update
// Assumes event and shutdown inputs synchronous to core_clk, pad logic outside
// Functional notes
// R1 - Zero phase count bypasses the stage, passing the event straight through.
// R2 - Each enabled stage output is clock-synchronous; total uncertainty stays one period.
// R3 - Stage order: blanking, then phase, then dead band, which re-arms blanking.
// R4 - Count N gives a delay between N and N plus one generator periods.
// R5 - Shutdown overrides both outputs until the first rising event after clearing.
// R6 - Software setting shutdown-active enters shutdown; clearing it restarts on rising event.
// R7 - A selected external shutdown input forces override levels at once, resetting drive.
// R8 - Five independently enabled sources; comparators and fault pin are active low.
// R9 - Shutdown inputs are levels; an asserted selected input holds shutdown.
// R10 - Two-bit override per output: low, high, tri-state or inactive PWM level. For output B, 11 drives !pol_b, which is B's active level.
// R11 - Polarity does not alter forced low or forced high override levels.
// R12 - Auto-restart bit chooses software restart or automatic restart.
// R13 - Software clear of shutdown-active is refused while any selected input is true.
// R14 - With auto-restart, hardware clears shutdown-active once inputs are false.
// R15 - While disabled, count writes reach the active buffers immediately.
// R16 - While enabled, counts move together only after the load bit is set.
// R17 - Hardware clears the load bit when the transfer completes.
// R18 - Block runs in sleep; fast oscillator kept on when enabled and selected.
// R19 - Outputs and fault input may be routed to alternate pins.
// R20 - Host programs everything while disabled, then enables and releases shutdown.
// R21 - Host programs both override levels before start; start is from shutdown.
// R22 - Shutdown set while disabled clears only by an enabled rising event or reset.
// R23 - Clock source: 00 system, 01 divided by four, 10 fast oscillator, 11 reserved.
// R24 - Shutdown inputs synchronised for status only; override path is combinational.
`timescale 1ns/10ps
`include "cogsd_consts.svh"
module cogsd_top #(
   parameter int CW = 8
) (
   input  wire logic       core_clk,          // 125 MHz system clock
   input  wire logic       rst_n,             // Asynchronous reset, active low
   input  wire logic [3:0] bus_addr,          // Register word address
   input  wire logic [7:0] bus_wdata,         // Write data
   input  wire logic       bus_wr,            // Write strobe
   input  wire logic       bus_rd,            // Read strobe
   output logic      [7:0] bus_rdata,         // Read data, cycle after strobe
   input  wire logic       rise_src,          // Selected rising event source
   input  wire logic       fall_src,          // Selected falling event source
   input  wire logic       limit_timer_one_output, // Shutdown source, high true
   input  wire logic       limit_timer_two_output, // Shutdown source, high true
   input  wire logic       comparator_one_result,  // Shutdown source, low true
   input  wire logic       comparator_two_result,  // Shutdown source, low true
   input  wire logic       fault_input_pin,   // Default fault pin, low true
   input  wire logic       fault_input_alt,   // Alternate fault pin, low true
   input  wire logic       fast_osc_tick,     // Fast oscillator rate pulse
   output logic            drive_output_a,    // Output A on default pin
   output logic            drive_output_a_oe, // Output A default pin enable
   output logic            drive_output_b,    // Output B on default pin
   output logic            drive_output_b_oe, // Output B default pin enable
   output logic            drive_output_a_alt,    // Output A on alternate pin
   output logic            drive_output_a_alt_oe, // Output A alternate enable
   output logic            drive_output_b_alt,    // Output B on alternate pin
   output logic            drive_output_b_alt_oe, // Output B alternate enable
   output logic            fast_osc_keep_on   // Request fast oscillator in sleep
);
   logic rst_m_r;
   logic rst_s_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_r <= 1'b0;
         rst_s_n <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_s_n <= rst_m_r;
      end
   end

   logic [7:0] ctrl_a_r;
   logic [1:0] cs_r;
   logic       arsen_r;
   logic [1:0] lvl_a_r;
   logic [1:0] lvl_b_r;
   logic [4:0] sd_en_r;
   logic [2:0] alt_r;
   logic       asde_r;
   logic       ld_r;
   logic [5:0][CW-1:0] cnt_hold_r;
   logic [5:0][CW-1:0] cnt_act_r;
   logic [7:0] rdata_r;
   logic [4:0] sd_m_r;
   logic [4:0] sd_s_r;
   cogsd_pkg::cogsd_st_t st_r;
   cogsd_pkg::cogsd_st_t st_nxt;
   logic       pwm_on_r;
   logic       rise_q_r;
   logic       fall_q_r;

   // Address decode
   wire wr_ca  = bus_wr && (bus_addr == `COGSD_OFF_CTRL_A);
   wire wr_cb  = bus_wr && (bus_addr == `COGSD_OFF_CTRL_B);
   wire wr_sdc = bus_wr && (bus_addr == `COGSD_OFF_SD_CTRL);
   wire wr_sds = bus_wr && (bus_addr == `COGSD_OFF_SD_SRC);
   wire wr_alt = bus_wr && (bus_addr == `COGSD_OFF_ALT_PIN);
   wire wr_cnt = bus_wr && (bus_addr >= `COGSD_OFF_CNT0) && (bus_addr <= `COGSD_OFF_CNT5);
   wire [3:0] cnt_off = bus_addr - `COGSD_OFF_CNT0;
   wire [2:0] cnt_idx = cnt_off[2:0];
   wire en = ctrl_a_r[`COGSD_CA_EN];
   wire pol_a = ctrl_a_r[`COGSD_CA_POL0];
   wire pol_b = ctrl_a_r[`COGSD_CA_POL1];
   wire wr_ld = wr_ca && bus_wdata[`COGSD_CA_LD];

   // Shutdown sources
   wire fault_lvl = alt_r[2] ? fault_input_alt : fault_input_pin; // R19
   wire [4:0] sd_raw = {limit_timer_two_output, limit_timer_one_output,
                        !comparator_two_result, !comparator_one_result, !fault_lvl}; // R8
   wire sd_any = |(sd_raw & sd_en_r); // R8 R9 R24

   logic gen_tick;
   cogsd_tick u_tick (
      .core_clk  (core_clk),
      .rst_n     (rst_s_n),
      .cs        (cogsd_pkg::cogsd_cs_t'(cs_r)),
      .fast_tick (fast_osc_tick),
      .en        (en),
      .gen_tick  (gen_tick),
      .osc_keep  (fast_osc_keep_on)
   );

   // Stage chain
   logic blk_r_busy;
   logic blk_f_busy;
   logic rise_lvl;
   logic fall_lvl;
   logic db_a;
   logic db_b;
   wire rise_in = rise_src && en && !blk_f_busy; // R3
   wire fall_in = fall_src && en && !blk_r_busy; // R3

   cogsd_stage #(.W(CW)) u_ph_r (
      .core_clk (core_clk), .rst_n (rst_s_n), .tick (gen_tick), .cnt (cnt_act_r[0]),
      .in_lvl (rise_in), .out_lvl (rise_lvl), .busy ()
   );
   cogsd_stage #(.W(CW)) u_ph_f (
      .core_clk (core_clk), .rst_n (rst_s_n), .tick (gen_tick), .cnt (cnt_act_r[1]),
      .in_lvl (fall_in), .out_lvl (fall_lvl), .busy ()
   );
   cogsd_stage #(.W(CW)) u_db_r (
      .core_clk (core_clk), .rst_n (rst_s_n), .tick (gen_tick), .cnt (cnt_act_r[2]),
      .in_lvl (pwm_on_r), .out_lvl (db_a), .busy ()
   );
   cogsd_stage #(.W(CW)) u_db_f (
      .core_clk (core_clk), .rst_n (rst_s_n), .tick (gen_tick), .cnt (cnt_act_r[3]),
      .in_lvl (!pwm_on_r), .out_lvl (db_b), .busy ()
   );
   // Blanking is re-armed by the dead-band outputs going false
   cogsd_stage #(.W(CW)) u_blk_r (
      .core_clk (core_clk), .rst_n (rst_s_n), .tick (gen_tick), .cnt (cnt_act_r[4]),
      .in_lvl (!db_b), .out_lvl (), .busy (blk_r_busy)
   );
   cogsd_stage #(.W(CW)) u_blk_f (
      .core_clk (core_clk), .rst_n (rst_s_n), .tick (gen_tick), .cnt (cnt_act_r[5]),
      .in_lvl (!db_a), .out_lvl (), .busy (blk_f_busy)
   );

   wire rise_edge = rise_lvl && !rise_q_r;
   wire fall_edge = fall_lvl && !fall_q_r;
   wire sd_hold = sd_any || asde_r;
   // Release only on an enabled rising event with every cause gone
   wire restart = rise_edge && en && !sd_hold; // R5 R6 R22

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         cogsd_pkg::COGSD_ST_RUN:  if (sd_hold) st_nxt = cogsd_pkg::COGSD_ST_SHUT; // R6 R7
         cogsd_pkg::COGSD_ST_SHUT: if (restart) st_nxt = cogsd_pkg::COGSD_ST_RUN; // R5 R22
      endcase
   end
   // Software-set shutdown overrides at once too, not a cycle later via the state
   wire override = (st_r == cogsd_pkg::COGSD_ST_SHUT) || sd_hold; // R5 R6 R7 R24

   // Shutdown-active bit: hardware set wins over any clear
   wire asde_nxt = sd_any ? 1'b1 :                                     // R9 R13
                   wr_sdc ? bus_wdata[`COGSD_SD_ASDE] :                // R6
                   arsen_r ? 1'b0 : asde_r;                             // R12 R14

   always_ff @(posedge core_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         st_r     <= cogsd_pkg::COGSD_ST_SHUT; // R21
         asde_r   <= 1'b0;
         pwm_on_r <= 1'b0;
         rise_q_r <= 1'b0;
         fall_q_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         asde_r   <= asde_nxt;
         rise_q_r <= rise_lvl;
         fall_q_r <= fall_lvl;
         if (sd_any || !en)                  pwm_on_r <= 1'b0; // R7
         else if (fall_edge)                 pwm_on_r <= 1'b0;
         else if (rise_edge && !asde_r)      pwm_on_r <= 1'b1;
      end
   end

   // Control registers
   always_ff @(posedge core_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         ctrl_a_r <= `COGSD_RST_BYTE;
         cs_r     <= 2'h0;
         arsen_r  <= 1'b0;
         lvl_a_r  <= 2'h0;
         lvl_b_r  <= 2'h0;
         sd_en_r  <= 5'h00;
         alt_r    <= 3'h0;
      end else begin
         if (wr_ca)  ctrl_a_r <= {bus_wdata[7:3], 3'h0};
         if (wr_cb)  cs_r     <= bus_wdata[1:0]; // R23
         if (wr_sdc) arsen_r  <= bus_wdata[`COGSD_SD_ARSEN]; // R12
         if (wr_sdc) lvl_a_r  <= bus_wdata[`COGSD_SD_LVLA_HI:`COGSD_SD_LVLA_LO]; // R10
         if (wr_sdc) lvl_b_r  <= bus_wdata[`COGSD_SD_LVLB_HI:`COGSD_SD_LVLB_LO]; // R10
         if (wr_sds) sd_en_r  <= bus_wdata[4:0]; // R8
         if (wr_alt) alt_r    <= bus_wdata[2:0]; // R19
      end
   end

   // Count buffers
   wire xfer = ld_r && gen_tick; // R16
   always_ff @(posedge core_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         cnt_hold_r <= '0;
         cnt_act_r  <= '0;
         ld_r       <= 1'b0;
      end else begin
         if (wr_cnt) cnt_hold_r[cnt_idx] <= bus_wdata[CW-1:0];
         if (xfer) cnt_act_r <= cnt_hold_r; // R16
         if (wr_cnt && !en) cnt_act_r[cnt_idx] <= bus_wdata[CW-1:0]; // R15
         if (wr_ld)     ld_r <= 1'b1;
         else if (xfer) ld_r <= 1'b0; // R17
      end
   end

   // Status synchroniser, readback only
   always_ff @(posedge core_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sd_m_r <= 5'h00;
         sd_s_r <= 5'h00;
      end else begin
         sd_m_r <= sd_raw;
         sd_s_r <= sd_m_r; // R24
      end
   end

   // Register read
   wire [7:0] rd_ca  = {ctrl_a_r[7:3], ld_r, 2'h0};
   wire [7:0] rd_sdc = {asde_r, arsen_r, lvl_b_r, lvl_a_r, 2'h0};
   wire [7:0] rd_st  = {(st_r == cogsd_pkg::COGSD_ST_SHUT), pwm_on_r, 1'b0, sd_s_r};
   wire [7:0] rd_cnt = 8'(cnt_hold_r[cnt_idx]);
   wire [7:0] rd_mux =
      (bus_addr == `COGSD_OFF_CTRL_A)  ? rd_ca :
      (bus_addr == `COGSD_OFF_CTRL_B)  ? {6'h00, cs_r} :
      (bus_addr == `COGSD_OFF_SD_CTRL) ? rd_sdc :
      (bus_addr == `COGSD_OFF_SD_SRC)  ? {3'h0, sd_en_r} :
      (bus_addr == `COGSD_OFF_STATUS)  ? rd_st :
      (bus_addr == `COGSD_OFF_ALT_PIN) ? {5'h00, alt_r} :
      ((bus_addr >= `COGSD_OFF_CNT0) && (bus_addr <= `COGSD_OFF_CNT5)) ? rd_cnt : 8'h00;
   always_ff @(posedge core_clk or negedge rst_s_n) begin
      if (!rst_s_n)    rdata_r <= 8'h00;
      else if (bus_rd) rdata_r <= rd_mux;
      else             rdata_r <= 8'h00;
   end
   assign bus_rdata = rdata_r;

   // Output levels; override bypasses flops so a fault acts at once
   wire pwm_a = db_a ^ pol_a;
   wire pwm_b = db_b ^ pol_b;
   wire ovr_a = (lvl_a_r == cogsd_pkg::COGSD_LVL_HIGH) ? 1'b1 :          // R11
                (lvl_a_r == cogsd_pkg::COGSD_LVL_INACT) ? pol_a : 1'b0; // R10
   wire ovr_b = (lvl_b_r == cogsd_pkg::COGSD_LVL_HIGH) ? 1'b1 :          // R11
                (lvl_b_r == cogsd_pkg::COGSD_LVL_INACT) ? !pol_b : 1'b0; // R10
   wire val_a = override ? ovr_a : pwm_a; // R5 R7
   wire val_b = override ? ovr_b : pwm_b; // R5 R7
   wire oe_a = ctrl_a_r[`COGSD_CA_OE0] && !(override && (lvl_a_r == cogsd_pkg::COGSD_LVL_TRI)); // R10
   wire oe_b = ctrl_a_r[`COGSD_CA_OE1] && !(override && (lvl_b_r == cogsd_pkg::COGSD_LVL_TRI)); // R10
   assign drive_output_a        = val_a;
   assign drive_output_b        = val_b;
   assign drive_output_a_alt    = val_a;
   assign drive_output_b_alt    = val_b;
   assign drive_output_a_oe     = oe_a && !alt_r[0]; // R19
   assign drive_output_a_alt_oe = oe_a && alt_r[0];  // R19
   assign drive_output_b_oe     = oe_b && !alt_r[1]; // R19
   assign drive_output_b_alt_oe = oe_b && alt_r[1];  // R19

   property p_sd_now;
      @(posedge core_clk) disable iff (!rst_s_n)
      sd_any && (lvl_b_r == cogsd_pkg::COGSD_LVL_LOW) |-> !val_b ##1 !pwm_on_r;
   endproperty
   a_sd_now: assert property (p_sd_now) else $error("fault did not override B"); // R7
   property p_refuse_clear;
      @(posedge core_clk) disable iff (!rst_s_n)
      sd_any && wr_sdc && !bus_wdata[`COGSD_SD_ASDE] |=> asde_r;
   endproperty
   a_refuse_clear: assert property (p_refuse_clear) else $error("clear accepted during fault"); // R13
   property p_ovr_hold;
      @(posedge core_clk) disable iff (!rst_s_n)
      (st_r == cogsd_pkg::COGSD_ST_SHUT) && !restart |=> (st_r == cogsd_pkg::COGSD_ST_SHUT);
   endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("override left early"); // R5
   property p_auto;
      @(posedge core_clk) disable iff (!rst_s_n)
      asde_r && arsen_r && !sd_any && !wr_sdc |=> !asde_r;
   endproperty
   a_auto: assert property (p_auto) else $error("auto restart missed"); // R14
   property p_forced;
      @(posedge core_clk) disable iff (!rst_s_n)
      override && (lvl_b_r == cogsd_pkg::COGSD_LVL_HIGH) |-> val_b;
   endproperty
   a_forced: assert property (p_forced) else $error("forced high inverted"); // R11
   property p_ld_clr;
      @(posedge core_clk) disable iff (!rst_s_n)
      xfer && !wr_ld |=> !ld_r && (cnt_act_r == $past(cnt_hold_r));
   endproperty
   a_ld_clr: assert property (p_ld_clr) else $error("load bit not cleared"); // R17
   property p_buf_dis;
      @(posedge core_clk) disable iff (!rst_s_n)
      wr_cnt && !en |=> (cnt_act_r[$past(cnt_idx)] == $past(bus_wdata[CW-1:0]));
   endproperty
   a_buf_dis: assert property (p_buf_dis) else $error("disabled write not loaded"); // R15
   property p_buf_en;
      @(posedge core_clk) disable iff (!rst_s_n)
      en && !xfer && !(wr_cnt && !en) |=> $stable(cnt_act_r);
   endproperty
   a_buf_en: assert property (p_buf_en) else $error("buffer changed without load"); // R16
endmodule // cogsd_top

// ---- test/cogsd_fault_src.sv ----
// Fault source model: shutdown requests turned into pin levels
// Assumes req bits follow the shutdown source select order
`timescale 1ns/10ps
module cogsd_fault_src (
   input  wire logic [4:0] req,  // Source asserted, high true
   output logic            flt,  // Fault pin
   output logic            cmp1, // Comparator one result
   output logic            cmp2, // Comparator two result
   output logic            tmr1, // Limit timer one output
   output logic            tmr2  // Limit timer two output
);
   assign flt  = ~req[0];
   assign cmp1 = ~req[1];
   assign cmp2 = ~req[2];
   assign tmr1 = req[3];
   assign tmr2 = req[4];
endmodule // cogsd_fault_src

// ---- test/tb_top.sv ----
// Self-checking bench of the shutdown/timing block
// Assumes the fault source model; fall events held idle, alternate fault pin idle until driven low near the end
`timescale 1ns/10ps
`include "cogsd_consts.svh"
module tb_top;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rise = 0, ftk = 0, rd_q = 0;
   logic [3:0]  addr = 0;
   logic [7:0]  wd = 0, rdata, cnt;
   logic [4:0]  req = 0;
   logic        fl, c1, c2, t1, t2, oa, oa_e, ob, ob_e, keep, oa_ae, ob_ae, fa = 1;
   logic [15:0] q[$];
   int          n_mismatch = 0, n_compared = 0, cyc = 0, seed = 32'hBB616C05;
   cogsd_top #(.CW(8)) uut (.core_clk(clk), .rst_n(rst_n), .bus_addr(addr), .bus_wdata(wd), .bus_wr(wr),
      .bus_rd(rd), .bus_rdata(rdata), .rise_src(rise), .fall_src(1'b0), .limit_timer_one_output(t1),
      .limit_timer_two_output(t2), .comparator_one_result(c1), .comparator_two_result(c2),
      .fault_input_pin(fl), .fault_input_alt(fa), .fast_osc_tick(ftk), .drive_output_a(oa),
      .drive_output_a_oe(oa_e), .drive_output_b(ob), .drive_output_b_oe(ob_e), .drive_output_a_alt(),
      .drive_output_a_alt_oe(oa_ae), .drive_output_b_alt(), .drive_output_b_alt_oe(ob_ae),
      .fast_osc_keep_on(keep));
   cogsd_fault_src fsrc (.req(req), .flt(fl), .cmp1(c1), .cmp2(c2), .tmr1(t1), .tmr2(t2));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ftk <= (cyc % 4 == 0);
      rd_q <= rd;
      if (rd_q) begin
         chk(rdata & q[0][15:8], q[0][7:0]);
         void'(q.pop_front());
      end
      if (cyc == 5000) begin
         n_mismatch++;
         end_sim;
      end
   end
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      q.push_back({m, e});
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      @(posedge clk);
   endtask
   // Long rise pulse so a small phase count still ends inside it
   task automatic restart;
      rise <= 1;
      repeat (8) @(posedge clk);
      rise <= 0;
      repeat (30) begin
         if (oa_e !== 1'b1) @(posedge clk);
      end
      chk(oa_e, 1);
      repeat (10) @(posedge clk);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      chk(oa_e, 0);
      for (int a = 0; a < 16; a++)
         rreg(4'(a), a == 10 ? 8'h80 : 8'hFF, a == 10 ? 8'h80 : 8'h00);
      for (int p = 0; p < 2; p++)
         for (int l = 0; l < 4; l++) begin
            wreg(`COGSD_OFF_CTRL_A, {3'b011, 1'(p), 1'(p), 3'b000});
            wreg(`COGSD_OFF_SD_CTRL, {2'b00, 2'(l), 2'(l), 2'b00});
            chk(oa_e, l != 2);
            chk(ob_e, l != 2);
            if (l != 2) begin
               chk(oa, l == 3 ? p == 1 : l == 1);
               chk(ob, l == 3 ? p == 0 : l == 1);
            end
         end
      for (int i = 0; i < 6; i++) begin
         cnt = $random(seed) & 8'h03;
         wreg(`COGSD_OFF_CNT0 + 4'(i), cnt);
         rreg(`COGSD_OFF_CNT0 + 4'(i), 8'hFF, cnt);
      end
      wreg(`COGSD_OFF_SD_CTRL, 8'h88);
      wreg(`COGSD_OFF_CTRL_A, 8'hE0);
      wreg(`COGSD_OFF_SD_CTRL, 8'h08);
      restart;
      for (int i = 0; i < 5; i++) begin
         wreg(`COGSD_OFF_SD_SRC, 8'(1 << i));
         req <= 5'(1 << i);
         #1;
         chk(oa_e, 0);
         @(posedge clk);
         rreg(`COGSD_OFF_SD_CTRL, 8'hFF, 8'h88);
         wreg(`COGSD_OFF_SD_CTRL, 8'h08);
         rreg(`COGSD_OFF_SD_CTRL, 8'hFF, 8'h88);
         req <= 0;
         wreg(`COGSD_OFF_SD_CTRL, 8'h08);
         rreg(`COGSD_OFF_SD_CTRL, 8'hFF, 8'h08);
         chk(oa_e, 0);
         restart;
      end
      wreg(`COGSD_OFF_SD_CTRL, 8'h88);
      chk(oa_e, 0);
      wreg(`COGSD_OFF_SD_CTRL, 8'h48);
      rreg(`COGSD_OFF_SD_CTRL, 8'hFF, 8'h48);
      chk(oa_e, 0);
      restart;
      req <= 5'h10;
      repeat (2) @(posedge clk);
      rreg(`COGSD_OFF_SD_CTRL, 8'hFF, 8'hC8);
      req <= 0;
      repeat (3) @(posedge clk);
      rreg(`COGSD_OFF_SD_CTRL, 8'hFF, 8'h48);
      chk(oa_e, 0);
      restart;
      wreg(`COGSD_OFF_CNT0, 8'h01);
      wreg(`COGSD_OFF_CTRL_A, 8'hE4);
      repeat (4) @(posedge clk);
      rreg(`COGSD_OFF_CTRL_A, 8'hFF, 8'hE0);
      for (int c = 0; c < 4; c++) begin
         wreg(`COGSD_OFF_CTRL_B, 8'(c));
         rreg(`COGSD_OFF_CTRL_B, 8'hFF, 8'(c));
         chk(keep, c == 2);
      end
      wreg(`COGSD_OFF_ALT_PIN, 8'h07);
      chk({oa_e, ob_e, oa_ae, ob_ae}, 8'h03);
      wreg(`COGSD_OFF_SD_SRC, 8'h01);
      req <= 5'h01;
      #1;
      chk(oa_ae, 1);
      @(posedge clk);
      fa <= 0;
      #1;
      chk(oa_ae, 0);
      @(posedge clk);
      wreg(`COGSD_OFF_CTRL_B, 8'h02);
      wreg(`COGSD_OFF_CTRL_A, 8'h60);
      chk(keep, 0);
      repeat (3) @(posedge clk);
      end_sim;
   end
endmodule // tb_top
